// >>> design/vfc_pkg.sv
package vfc_pkg;

    // ****************************************************************
    // Register map (byte offsets) and control fields
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PRESET  = 8'h04;
    localparam logic [7:0] ADDR_TH_LO   = 8'h08;
    localparam logic [7:0] ADDR_TH_HI   = 8'h0C;
    localparam logic [7:0] ADDR_VALUE   = 8'h10;
    localparam logic [7:0] ADDR_CAPTURE = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;

    localparam int CTL_ENABLE    = 0;
    localparam int CTL_REINIT    = 1;
    localparam int CTL_DONE_CLR  = 2;
    localparam int CTL_PIN_EN    = 3;
    localparam int CTL_TIME_BASE = 4;
    localparam int CTL_MODE_LSB  = 8;

    localparam int STS_DONE  = 0;
    localparam int STS_DIR   = 1;
    localparam int STS_LO    = 2;
    localparam int STS_HI    = 3;
    localparam int STS_VALID = 4;

    localparam logic [31:0] PRESET_RESET = 32'h0000FFFF;

    // ****************************************************************
    // Modes: software code and internal one-hot form
    // ****************************************************************
    localparam logic [2:0] CODE_UPDOWN = 3'h1;
    localparam logic [2:0] CODE_QUAD   = 3'h2;
    localparam logic [2:0] CODE_UP     = 3'h3;
    localparam logic [2:0] CODE_DOWN   = 3'h4;
    localparam logic [2:0] CODE_FREQ   = 3'h5;

    typedef enum logic [5:0] {
        MODE_OFF    = 6'h01,
        MODE_UPDOWN = 6'h02,
        MODE_QUAD   = 6'h04,
        MODE_UP     = 6'h08,
        MODE_DOWN   = 6'h10,
        MODE_FREQ   = 6'h20
    } count_mode_t;

    // ****************************************************************
    // Time base of the frequency gate
    // ****************************************************************
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned GATE_MS     = 100;
    localparam int unsigned GATE_LONG_S = 1;
    localparam int unsigned GATE_CYC    = CLK_HZ / 1000 * GATE_MS;
    localparam int unsigned GATE_LONG_CYC = CLK_HZ * GATE_LONG_S;

    // Pin bundle order after synchronisation
    typedef struct packed {
        logic catch_in;
        logic preset_in;
        logic dir;
        logic pulse;
    } pins_t;

endpackage

// >>> design/vfc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module vfc_sync
    import vfc_pkg::*;
(
    input  wire logic mclk_i,      // System clock
    input  wire logic reset_n_i,   // Synchronous reset, active low
    input  wire pins_t pin_i,      // Raw field pins
    output pins_t      level_o,    // Synchronised levels
    output pins_t      rise_o      // One-cycle rising edge pulses
);

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t s3;
    } sync_t;

    sync_t q;
    sync_t d;

    // ****************************************************************
    // Two-stage sync, third stage for edge compare
    // ****************************************************************
    always_comb begin
        d    = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_o = q.s2;
    assign rise_o  = q.s2 & ~q.s3;

endmodule
`default_nettype wire

// >>> design/very_fast_counter.sv
// Operation
// - Mode select: off, up/down, two-phase, up, down, frequency meter.
// - Counter steps per mode; preset input can load the preset value.
// - Up/down mode shows direction of last step: 0 up, 1 down.
// - Down, up/down, two-phase: preset edge or reinit loads preset value.
// - New preset value takes effect on reinit or when the running cycle ends.
// - Frequency mode: catch rising edge copies value into capture.
// - Lower flag is 1 while value >= lower threshold, else 0.
// - Upper flag is 1 while value >= upper threshold, else 0.
// - Done sets at preset in up mode, at zero in down, up/down.
// - Done clears on reinit or while done clear is 1.
// - Done clear is a level; software must drop it itself.
// - Frequency time base bit: 0 is 100 ms, 1 is 1 s.
// - Preset pin rising edge forces value to preset, except in off and frequency modes; low pin no effect.
// - Preset pin acts only while preset input enable is set.
// - Each counter instance drives its own pair of reflex outputs.
// - Value follows pulses only while count enable is 1.
// - Single up mode: reinit sets value to zero.
// - Up mode: reaching preset sets done and returns value to zero.
// - Counting only on pulse rising edges while enabled.
`timescale 1ns/1ns
`default_nettype none
module very_fast_counter
    import vfc_pkg::*;
#(
    parameter int unsigned GATE_SHORT = GATE_CYC,      // 100 ms gate in cycles
    parameter int unsigned GATE_LONG  = GATE_LONG_CYC  // 1 s gate in cycles
) (
    input  wire logic        mclk_i,                   // 25 MHz clock
    input  wire logic        reset_n_i,                // Sync reset, active low
    input  wire logic [7:0]  addr_i,                   // Register byte address
    input  wire logic [31:0] wdata_i,                  // Write data
    input  wire logic        wr_i,                     // Write strobe
    input  wire logic        rd_i,                     // Read strobe
    output logic      [31:0] rdata_o,                  // Read data, next cycle
    input  wire logic        pulse_i,                  // Pulse or phase A pin
    input  wire logic        dir_i,                    // Direction or phase B pin
    input  wire logic        preset_input_i,           // Preset pin
    input  wire logic        catch_input_i,            // Catch pin
    output logic             done_flag_o,              // Done flag
    output logic             direction_flag_o,         // 1 after a down step in up/down mode
    output logic             lower_threshold_flag_o,   // Value >= lower threshold
    output logic             upper_threshold_flag_o,   // Value >= upper threshold
    output logic             reflex_out_a0_o,          // Reflex output 0
    output logic             reflex_out_a1_o           // Reflex output 1
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0]  mode_sel;
        count_mode_t mode;
        logic        enable;
        logic        pin_enable;
        logic        time_base;
        logic        done_clear;
        logic        started;
        logic [31:0] value;
        logic [31:0] preset_wr;
        logic [31:0] preset_act;
        logic [31:0] capture;
        logic [31:0] th_lo_wr;
        logic [31:0] th_hi_wr;
        logic [31:0] th_lo;
        logic [31:0] th_hi;
        logic [31:0] accum;
        logic [31:0] gate;
        logic        done;
        logic        dir;
        logic        flag_lo;
        logic        flag_hi;
        logic        freq_valid;
        logic        reflex0;
        logic        reflex1;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;
    pins_t  raw;
    pins_t  lvl;
    pins_t  rise;
    logic   reinit;
    logic   up_ev;
    logic   dn_ev;
    logic   preset_ev;
    logic   run;
    logic   gate_end;
    logic [31:0] nxt;
    logic [31:0] gate_lim;

    function automatic count_mode_t decode(input logic [2:0] code);
        case (code)
            CODE_UPDOWN: decode = MODE_UPDOWN;
            CODE_QUAD:   decode = MODE_QUAD;
            CODE_UP:     decode = MODE_UP;
            CODE_DOWN:   decode = MODE_DOWN;
            CODE_FREQ:   decode = MODE_FREQ;
            default:     decode = MODE_OFF;
        endcase
    endfunction

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    assign raw = '{catch_in: catch_input_i, preset_in: preset_input_i,
                   dir: dir_i, pulse: pulse_i};

    vfc_sync u_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (raw),
        .level_o   (lvl),
        .rise_o    (rise)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d        = q;
        d.rdata  = '0;
        reinit   = 1'b0;
        up_ev    = 1'b0;
        dn_ev    = 1'b0;
        nxt      = q.value;
        gate_end = 1'b0;
        gate_lim = q.time_base ? 32'(GATE_LONG) : 32'(GATE_SHORT);
        run      = q.started && q.enable;
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL:    d.rdata = {21'h0, q.mode_sel, 3'h0, q.time_base,
                                         q.pin_enable, q.done_clear, 1'b0, q.enable};
                ADDR_PRESET:  d.rdata = q.preset_wr;
                ADDR_TH_LO:   d.rdata = q.th_lo_wr;
                ADDR_TH_HI:   d.rdata = q.th_hi_wr;
                ADDR_VALUE:   d.rdata = q.value;
                ADDR_CAPTURE: d.rdata = q.capture;
                ADDR_STATUS:  d.rdata = {27'h0, q.freq_valid, q.flag_hi, q.flag_lo,
                                         q.dir, q.done};
                default:      d.rdata = '0;
            endcase
        end
        if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: begin
                    d.enable     = wdata_i[CTL_ENABLE];
                    d.done_clear = wdata_i[CTL_DONE_CLR];
                    d.pin_enable = wdata_i[CTL_PIN_EN];
                    d.time_base  = wdata_i[CTL_TIME_BASE];
                    d.mode_sel   = wdata_i[CTL_MODE_LSB +: 3];
                    reinit       = wdata_i[CTL_REINIT];
                end
                ADDR_PRESET: d.preset_wr = wdata_i;
                ADDR_TH_LO:  d.th_lo_wr  = wdata_i;
                ADDR_TH_HI:  d.th_hi_wr  = wdata_i;
                default: ;
            endcase
        end
        // Pulse decoding per mode, rising edges only
        case (q.mode)
            MODE_UPDOWN: begin
                up_ev = rise.pulse && !lvl.dir;
                dn_ev = rise.pulse && lvl.dir;
            end
            MODE_QUAD: begin
                up_ev = rise.pulse && !lvl.dir;
                dn_ev = rise.pulse && lvl.dir;
            end
            MODE_UP:   up_ev = rise.pulse;
            MODE_DOWN: dn_ev = rise.pulse;
            default: ;
        endcase
        up_ev     = up_ev && run;
        dn_ev     = dn_ev && run;
        preset_ev = q.pin_enable && rise.preset_in && q.started
                    && (q.mode inside {MODE_UPDOWN, MODE_QUAD, MODE_UP, MODE_DOWN});
        if (reinit) begin
            d.started    = 1'b1;
            d.mode       = decode(d.mode_sel);
            d.preset_act = d.preset_wr;
            d.th_lo      = d.th_lo_wr;
            d.th_hi      = d.th_hi_wr;
            d.done       = 1'b0;
            d.freq_valid = 1'b0;
            d.accum      = '0;
            d.gate       = '0;
            d.dir        = 1'b0;
            if (d.mode inside {MODE_UP, MODE_FREQ, MODE_OFF}) begin
                d.value = '0;
            end else begin
                d.value = d.preset_wr;
            end
        end else if (preset_ev) begin
            d.value = q.preset_act;
        end else if (up_ev) begin
            nxt = q.value + 32'h1;
            if (q.mode == MODE_UP && nxt == q.preset_act) begin
                d.value      = '0;
                d.done       = 1'b1;
                d.preset_act = q.preset_wr;
            end else begin
                d.value = nxt;
            end
            if (q.mode == MODE_UPDOWN) begin
                d.dir = 1'b0;
            end
        end else if (dn_ev) begin
            nxt = q.value - 32'h1;
            if (q.mode == MODE_DOWN && nxt == '0) begin
                d.value      = q.preset_wr;
                d.preset_act = q.preset_wr;
                d.done       = 1'b1;
            end else begin
                d.value = nxt;
                if (q.mode == MODE_UPDOWN && nxt == '0) begin
                    d.done = 1'b1;
                end
            end
            if (q.mode == MODE_UPDOWN) begin
                d.dir = 1'b1;
            end
        end else if (q.mode == MODE_FREQ && run) begin
            d.gate   = q.gate + 32'h1;
            d.accum  = q.accum + {31'h0, rise.pulse};
            gate_end = (q.gate >= gate_lim - 32'h1);
            if (gate_end) begin
                d.value      = d.accum;
                d.accum      = '0;
                d.gate       = '0;
                d.freq_valid = 1'b1;
            end
        end
        if (q.mode == MODE_FREQ && rise.catch_in) begin
            d.capture = q.value;
        end
        // Clear level wins over a done event in the same cycle
        if (d.done_clear) begin
            d.done = 1'b0;
        end
        d.flag_lo = q.value >= q.th_lo;
        d.flag_hi = q.value >= q.th_hi;
        d.reflex0 = q.flag_lo && (q.mode != MODE_FREQ);
        d.reflex1 = q.flag_hi && (q.mode != MODE_FREQ);
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            q            <= '0;
            q.mode       <= MODE_OFF;
            q.preset_wr  <= PRESET_RESET;
            q.preset_act <= PRESET_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata_o                = q.rdata;
    assign done_flag_o            = q.done;
    assign direction_flag_o       = q.dir;
    assign lower_threshold_flag_o = q.flag_lo;
    assign upper_threshold_flag_o = q.flag_hi;
    assign reflex_out_a0_o        = q.reflex0;
    assign reflex_out_a1_o        = q.reflex1;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_reinit;
        wr_i && addr_i == ADDR_CTRL && wdata_i[CTL_REINIT];
    endsequence

    sequence s_up_wrap;
        !reinit && !preset_ev && up_ev && q.mode == MODE_UP
        && q.value + 32'h1 == q.preset_act;
    endsequence

    a_reinit_done_clr: assert property (s_reinit |=> !q.done)
        else $error("done still set after reinit");
    a_done_held_clr: assert property (q.done_clear |-> !q.done)
        else $error("done set while clear level high");
    a_hold_disabled: assert property (!q.enable && !reinit && !preset_ev
        |=> $stable(q.value))
        else $error("value moved while disabled");
    a_up_wrap_zero: assert property (s_up_wrap
        |=> q.value == '0 && q.done == !q.done_clear)
        else $error("up mode did not wrap at preset");
    a_down_reload: assert property (!reinit && !preset_ev && dn_ev
        && q.mode == MODE_DOWN && q.value == 32'h1
        |=> q.done == !q.done_clear && q.value == $past(q.preset_wr))
        else $error("down mode did not reload at zero");
    a_lo_flag_cmp: assert property ($past(reset_n_i)
        |-> q.flag_lo == ($past(q.value) >= $past(q.th_lo)))
        else $error("lower flag wrong");
    a_hi_flag_cmp: assert property ($past(reset_n_i)
        |-> q.flag_hi == ($past(q.value) >= $past(q.th_hi)))
        else $error("upper flag wrong");
    a_catch_copy: assert property (q.mode == MODE_FREQ && rise.catch_in
        |=> q.capture == $past(q.value))
        else $error("capture missed");
    a_preset_pin: assert property (preset_ev && !reinit
        |=> q.value == $past(q.preset_act))
        else $error("preset pin did not load");

endmodule
`default_nettype wire

// >>> bench/pulse_source.sv
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
    input  wire logic mclk_i,    // System clock
    output logic      pulse_o,   // Pulse or phase A pin
    output logic      dir_o,     // Direction or phase B pin
    output logic      preset_o,  // Preset pin
    output logic      catch_o    // Catch pin
);
    initial begin
        pulse_o = 1'b0;
        dir_o = 1'b0;
        preset_o = 1'b0;
        catch_o = 1'b0;
    end

    // Levels are held four clocks, four times the one clock the synchroniser needs
    task automatic pulses(input int n, input logic down);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_i);
            dir_o <= down;
            @(posedge mclk_i);
            pulse_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            pulse_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
    endtask

    // One high level on the preset pin (0) or the catch pin (1)
    task automatic strobe(input logic which);
        @(posedge mclk_i);
        if (which) catch_o <= 1'b1;
        else preset_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        catch_o <= 1'b0;
        preset_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import vfc_pkg::*;
    logic        mclk_i, reset_n_i, wr_i, rd_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic        pulse_i, dir_i, preset_input_i, catch_input_i;
    logic        done_flag_o, direction_flag_o, lower_flag, upper_flag;
    logic        reflex_out_a0_o, reflex_out_a1_o;
    int          n_errors = 0;
    int          n_tests = 0;

    very_fast_counter #(.GATE_SHORT(20), .GATE_LONG(50)) uut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pulse_i(pulse_i), .dir_i(dir_i),
        .preset_input_i(preset_input_i), .catch_input_i(catch_input_i),
        .done_flag_o(done_flag_o), .direction_flag_o(direction_flag_o),
        .lower_threshold_flag_o(lower_flag), .upper_threshold_flag_o(upper_flag),
        .reflex_out_a0_o(reflex_out_a0_o), .reflex_out_a1_o(reflex_out_a1_o));

    pulse_source src (.mclk_i(mclk_i), .pulse_o(pulse_i), .dir_o(dir_i),
        .preset_o(preset_input_i), .catch_o(catch_input_i));

    // ****************************************************************
    // Bus and compare helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        chk(what, exp, d);
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    // Control word: b0 enable, b1 reinit, b2 done clear, b3 pin enable, b4 time base
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [4:0] b);
        ctl = 32'h0;
        ctl[CTL_MODE_LSB +: 3] = m;
        ctl[4:0] = b;
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        chk_reg("preset", ADDR_PRESET, PRESET_RESET);
        chk_reg("ctrl", ADDR_CTRL, 32'h0);
        chk_reg("unmapped", 8'h1C, 32'h0);
        bus_wr(ADDR_VALUE, 32'h55);
        chk_reg("value ro", ADDR_VALUE, 32'h0);
        $display("test reset finished");
    endtask

    task automatic t_up;
        bus_wr(ADDR_PRESET, 32'h3);
        bus_wr(ADDR_TH_LO, 32'h1);
        bus_wr(ADDR_TH_HI, 32'h2);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h03));
        src.pulses(2, 1'b0);
        chk_reg("value", ADDR_VALUE, 32'h2);
        chk("done", 32'h0, done_flag_o);
        chk("lower flag", 32'h1, lower_flag);
        chk("upper flag", 32'h1, upper_flag);
        chk("reflex a0", 32'h1, reflex_out_a0_o);
        chk("reflex a1", 32'h1, reflex_out_a1_o);
        src.pulses(1, 1'b0);
        chk_reg("value", ADDR_VALUE, 32'h0);
        chk("done", 32'h1, done_flag_o);
        chk("upper flag", 32'h0, upper_flag);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h05));
        settle();
        chk("done", 32'h0, done_flag_o);
        src.pulses(3, 1'b0);
        chk("done", 32'h0, done_flag_o);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h01));
        settle();
        chk("done", 32'h0, done_flag_o);
        src.pulses(4, 1'b0);
        chk("done", 32'h1, done_flag_o);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h03));
        settle();
        chk("done", 32'h0, done_flag_o);
        chk_reg("value", ADDR_VALUE, 32'h0);
        $display("test up finished");
    endtask

    task automatic t_enable;
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h00));
        src.pulses(2, 1'b0);
        chk_reg("value", ADDR_VALUE, 32'h0);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h01));
        src.pulses(1, 1'b0);
        chk_reg("value", ADDR_VALUE, 32'h1);
        $display("test enable finished");
    endtask

    task automatic t_down;
        bus_wr(ADDR_CTRL, ctl(CODE_DOWN, 5'h03));
        chk_reg("value", ADDR_VALUE, 32'h3);
        src.pulses(1, 1'b0);
        bus_wr(ADDR_PRESET, 32'h5);
        chk_reg("value", ADDR_VALUE, 32'h2);
        src.pulses(2, 1'b0);
        chk("done", 32'h1, done_flag_o);
        chk_reg("value", ADDR_VALUE, 32'h5);
        src.pulses(1, 1'b0);
        bus_wr(ADDR_CTRL, ctl(CODE_DOWN, 5'h09));
        src.strobe(1'b0);
        chk_reg("value", ADDR_VALUE, 32'h5);
        src.pulses(1, 1'b0);
        bus_wr(ADDR_CTRL, ctl(CODE_DOWN, 5'h01));
        src.strobe(1'b0);
        chk_reg("value", ADDR_VALUE, 32'h4);
        $display("test down finished");
    endtask

    task automatic t_updown(input logic [2:0] m);
        bus_wr(ADDR_CTRL, ctl(m, 5'h03));
        chk_reg("value", ADDR_VALUE, 32'h5);
        src.pulses(1, 1'b1);
        chk_reg("value", ADDR_VALUE, 32'h4);
        if (m == CODE_UPDOWN) chk("direction", 32'h1, direction_flag_o);
        src.pulses(1, 1'b0);
        chk_reg("value", ADDR_VALUE, 32'h5);
        if (m == CODE_UPDOWN) chk("direction", 32'h0, direction_flag_o);
        $display("test two-way finished");
    endtask

    task automatic t_gate(input logic tb, input int lo, input int hi);
        int          n;
        logic [31:0] s;
        n = 0;
        s = 32'h0;
        bus_wr(ADDR_CTRL, ctl(CODE_FREQ, {tb, 4'h3}));
        while (s[STS_VALID] !== 1'b1 && n < 200) begin
            bus_rd(ADDR_STATUS, s);
            n = n + 2;
        end
        chk("gate length", 32'h1, 32'(n >= lo && n <= hi));
        $display("test gate finished");
    endtask

    task automatic t_misc;
        bus_wr(ADDR_CTRL, ctl(3'h0, 5'h03));
        src.pulses(1, 1'b0);
        chk_reg("value off", ADDR_VALUE, 32'h0);
        bus_wr(ADDR_CTRL, ctl(CODE_UP, 5'h03));
        src.pulses(1, 1'b0);
        src.strobe(1'b1);
        chk_reg("capture", ADDR_CAPTURE, 32'h0);
        // Two pulses inside the first 20-cycle gate, catch while the count stands
        bus_wr(ADDR_CTRL, ctl(CODE_FREQ, 5'h03));
        src.pulses(2, 1'b0);
        src.strobe(1'b1);
        chk_reg("capture freq", ADDR_CAPTURE, 32'h2);
        chk_reg("freq count", ADDR_VALUE, 32'h2);
        chk("lower flag", 32'h1, lower_flag);
        chk("reflex a0", 32'h0, reflex_out_a0_o);
        $display("test misc finished");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, sequence and watchdog
    // ****************************************************************
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    initial begin
        reset_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_up();
        t_enable();
        t_down();
        t_updown(CODE_UPDOWN);
        t_updown(CODE_QUAD);
        t_gate(1'b0, 16, 30);
        t_gate(1'b1, 46, 60);
        t_misc();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
